// ---- logic/meter_interrupt_mask_status.sv ----
// interrupt mask and sticky status for the three-phase metering core
// assumes: detectors and serial port run on ref_clk; supply monitor
// arrives asynchronously from a pin
`timescale 1ns/100ps
`include "meter_irq_map.svh"
`default_nettype none

module meter_interrupt_mask_status
  import meter_irq_pkg::*;
(
  // clock and reset
  input  wire logic  ref_clk,
  input  wire logic  sys_rst,
  // register access from the serial port
  input  wire reg_addr_t regAddr,
  input  wire logic  regWrEn,
  input  wire logic  regRdEn,
  input  wire flags_t regWrData,
  output var flags_t regRdData_r,
  output var logic   regRdValid_r,
  // reset sources
  input  wire logic  supplyLowPin,
  input  wire logic  softResetReq,
  // accumulator watch bits, one per phase
  input  wire phase_t activeEnergyBit14,
  input  wire phase_t reactiveEnergyBit14,
  input  wire phase_t apparentEnergyBit15,
  // line events, one per phase
  input  wire phase_t voltageDip,
  input  wire phase_t crossingTimeout,
  input  wire phase_t zeroCross,
  // single events
  input  wire logic  lineCycleAccumDone,
  input  wire logic  voltagePeakExceeded,
  input  wire logic  currentPeakExceeded,
  input  wire logic  waveformSampleReady,
  // power signs and phase selection
  input  wire phase_t activePowerSign,
  input  wire phase_t reactivePowerSign,
  input  wire phase_t phaseTermSelect,
  // open-drain interrupt pin
  output var logic   irqOut_r,
  output var logic   irqOeN_r
);

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  flags_t     mask_r;        // enable mask
  flags_t     flags_r;       // sticky flags
  flags_t     flags_nxt;     // next flags
  flags_t     mask_nxt;      // next mask value
  flags_t     events;        // this cycle's events
  flags_t     flagsStk;      // sticky part, for checks
  logic [2:0] supSync_r;     // pin synchroniser
  logic       supLvl_r;      // filtered supply-low level
  logic       supDrop;       // supply went low
  logic       rstEvt;        // any reset event
  logic       rdMask;        // mask read
  logic       rdFlags;       // plain status read
  logic       rdClr;         // clearing status read
  logic       wrMask;        // mask write
  phase_t     actPrev_r;     // previous watch bits
  phase_t     reaPrev_r;
  phase_t     appPrev_r;
  phase_t     actSgnPrev_r;  // previous power signs
  phase_t     reaSgnPrev_r;
  logic       histValid_r;   // history holds real data
  seq_state_t seq_r;         // phase order state
  seq_state_t seq_nxt;
  logic       phase_order_error;        // A then B detected

  // ----------------------------------------
  // access decode
  // ----------------------------------------
  assign rdMask  = regRdEn && (regAddr == `MIS_MASK_ADDR);
  assign rdFlags = regRdEn && (regAddr == `MIS_FLAGS_ADDR);
  assign rdClr   = regRdEn && (regAddr == `MIS_CLRRD_ADDR);
  assign wrMask  = regWrEn && (regAddr == `MIS_MASK_ADDR);

  // ----------------------------------------
  // supply monitor synchroniser
  // ----------------------------------------
  // three stages; level only moves once stages 2 and 3 agree
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      supSync_r <= `MIS_SYNC_RST;
    end else begin
      supSync_r <= {supSync_r[1:0], supplyLowPin};
    end
  end

  // filtered level, glitch of one sample ignored
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      supLvl_r <= 1'b0;
    end else if (supSync_r[1] == supSync_r[2]) begin
      supLvl_r <= supSync_r[2];
    end
  end

  assign supDrop = (supSync_r[1] == supSync_r[2]) && supSync_r[2]
                   && !supLvl_r;
  // supply drop and software reset act alike
  assign rstEvt  = supDrop || softResetReq;

  // ----------------------------------------
  // history of watched bits
  // ----------------------------------------
  // the first sample after reset only primes history, so a
  // nonzero accumulator at start does not look like a change
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      actPrev_r    <= 3'h0;
      reaPrev_r    <= 3'h0;
      appPrev_r    <= 3'h0;
      actSgnPrev_r <= 3'h0;
      reaSgnPrev_r <= 3'h0;
      histValid_r  <= 1'b0;
    end else begin
      actPrev_r    <= activeEnergyBit14;
      reaPrev_r    <= reactiveEnergyBit14;
      appPrev_r    <= apparentEnergyBit15;
      actSgnPrev_r <= activePowerSign;
      reaSgnPrev_r <= reactivePowerSign;
      histValid_r  <= 1'b1;
    end
  end

  // ----------------------------------------
  // phase order tracker
  // ----------------------------------------
  always_comb begin
    seq_nxt = seq_r;
    phase_order_error  = 1'b0;
    unique case (seq_r)
      SEQ_IDLE: begin
        // wait for a phase A crossing
        if (zeroCross[0]) seq_nxt = SEQ_AFTER_A;
      end
      SEQ_AFTER_A: begin
        // next crossing decides: C (alone or with B) is fine, B alone is wrong
        if (zeroCross[1] && !zeroCross[2]) begin
          phase_order_error  = 1'b1;
          seq_nxt = SEQ_IDLE;
        end else if (zeroCross[2]) begin
          seq_nxt = SEQ_IDLE;
        end
      end
      default: seq_nxt = SEQ_IDLE; // illegal code recovers
    endcase
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      seq_r <= SEQ_IDLE;
    end else begin
      seq_r <= seq_nxt;
    end
  end

  // ----------------------------------------
  // event vector
  // ----------------------------------------
  always_comb begin
    events = '0;
    events[`MIS_BIT_ACTHF] = histValid_r
      && |(activeEnergyBit14 ^ actPrev_r);
    events[`MIS_BIT_REACHF] = histValid_r
      && |(reactiveEnergyBit14 ^ reaPrev_r);
    events[`MIS_BIT_APPHF] = histValid_r
      && |(apparentEnergyBit15 & ~appPrev_r);
    events[`MIS_BIT_DIP+:3]  = voltageDip;
    events[`MIS_BIT_ZXTO+:3] = crossingTimeout;
    events[`MIS_BIT_ZX+:3]   = zeroCross;
    events[`MIS_BIT_LCYC]    = lineCycleAccumDone;
    events[`MIS_BIT_PKV]     = voltagePeakExceeded;
    events[`MIS_BIT_PKI]     = currentPeakExceeded;
    events[`MIS_BIT_WAVE]    = waveformSampleReady;
    // only phases chosen by the select field count
    events[`MIS_BIT_REVA] = histValid_r
      && |((activePowerSign ^ actSgnPrev_r)
           & phaseTermSelect);
    events[`MIS_BIT_REVR] = histValid_r
      && |((reactivePowerSign ^ reaSgnPrev_r)
           & phaseTermSelect);
    events[`MIS_BIT_SEQ] = phase_order_error;
  end

  // ----------------------------------------
  // sticky flags
  // ----------------------------------------
  // set wins over a clear in the same cycle, so no event is lost
  always_comb begin
    flags_nxt = flags_r;
    if (rdClr || rstEvt) begin
      flags_nxt = '0;
    end
    flags_nxt = flags_nxt | events;
    // reset flag is a single-cycle marker, never sticky
    flags_nxt[`MIS_BIT_RST] = rstEvt;
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      flags_r <= `MIS_FLAGS_RST;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  assign flagsStk = flags_r & `MIS_STICKY;

  // ----------------------------------------
  // mask register
  // ----------------------------------------
  // reserved bit 13 cannot be set, so the reset marker never
  // reaches the pin
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mask_r <= `MIS_MASK_RST;
    end else if (rstEvt) begin
      mask_r <= `MIS_MASK_RST;
    end else if (wrMask) begin
      mask_r <= regWrData & `MIS_MASK_WRBITS;
    end
  end

  // ----------------------------------------
  // read data
  // ----------------------------------------
  // clearing read returns flags as they stood before the clear
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      regRdData_r  <= '0;
      regRdValid_r <= 1'b0;
    end else begin
      regRdValid_r <= regRdEn;
      if (rdMask) begin
        regRdData_r <= mask_r;
      end else if (rdFlags || rdClr) begin
        regRdData_r <= flags_r;
      end else begin
        regRdData_r <= '0; // unmapped reads give zero
      end
    end
  end

  // ----------------------------------------
  // interrupt pin
  // ----------------------------------------
  // enable taken from next values so pin and flags move together
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irqOeN_r <= 1'b1;
    end else begin
      irqOeN_r <= ~|(flags_nxt & mask_nxt);
    end
  end

  // pin data is always low; only the enable moves
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irqOut_r <= 1'b0;
    end else begin
      irqOut_r <= 1'b0;
    end
  end

  // next mask value, mirrors the mask process; a plain signal
  // rather than a function, so every read is a visible net
  always_comb begin
    mask_nxt = mask_r;
    if (rstEvt) begin
      mask_nxt = `MIS_MASK_RST;
    end else if (wrMask) begin
      mask_nxt = regWrData & `MIS_MASK_WRBITS;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_irq_low;
    @(posedge ref_clk) disable iff (sys_rst)
      (|(flags_r & mask_r)) |-> !irqOeN_r;
  endproperty
  a_irq_low: assert property (p_irq_low)
    else $error("masked flag set but pin released");

  property p_release;
    @(posedge ref_clk) disable iff (sys_rst)
      (rdClr && !(|events) && !rstEvt && !wrMask) |=> irqOeN_r;
  endproperty
  a_release: assert property (p_release)
    else $error("pin not released after clearing read");

  property p_set;
    @(posedge ref_clk) disable iff (sys_rst)
      (|events) |=> ((flags_r & $past(events)) == $past(events));
  endproperty
  a_set: assert property (p_set)
    else $error("event did not set its flag");

  property p_sticky;
    @(posedge ref_clk) disable iff (sys_rst)
      (!rdClr && !rstEvt) ##1 (!rdClr && !rstEvt) |=>
        ((flagsStk & $past(flagsStk, 2)) == $past(flagsStk, 2));
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("flag dropped without a clear");

  property p_clear;
    @(posedge ref_clk) disable iff (sys_rst)
      (rdClr && !(|events)) |=>
        (flagsStk == '0) && (regRdData_r == $past(flags_r));
  endproperty
  a_clear: assert property (p_clear)
    else $error("clearing read wrong data or no clear");

  property p_plain;
    @(posedge ref_clk) disable iff (sys_rst)
      (rdFlags && !rstEvt) |=> (flagsStk == $past(flagsStk))
        or (|$past(events));
  endproperty
  a_plain: assert property (p_plain)
    else $error("plain status read disturbed flags");

  property p_rst_pulse;
    @(posedge ref_clk) disable iff (sys_rst)
      rstEvt |=> flags_r[`MIS_BIT_RST] ##1
        (!flags_r[`MIS_BIT_RST] || $past(rstEvt));
  endproperty
  a_rst_pulse: assert property (p_rst_pulse)
    else $error("reset flag not a single-cycle pulse");

  property p_seq;
    @(posedge ref_clk) disable iff (sys_rst)
      (seq_r == SEQ_AFTER_A && zeroCross == 3'h2) |=>
        flags_r[`MIS_BIT_SEQ];
  endproperty
  a_seq: assert property (p_seq)
    else $error("A then B crossing not flagged");

  property p_rev;
    @(posedge ref_clk) disable iff (sys_rst)
      (histValid_r &&
       |((activePowerSign ^ actSgnPrev_r) & phaseTermSelect))
        |=> flags_r[`MIS_BIT_REVA];
  endproperty
  a_rev: assert property (p_rev)
    else $error("selected sign flip not flagged");

endmodule : meter_interrupt_mask_status
`default_nettype wire

// ---- logic/meter_irq_map.svh ----
// constants for the metering interrupt mask and status block
// assumes: included by the block, the host model and the bench, 7-bit register addresses
//
// Summary of operation
// - masked pending event pulls interrupt pin low
// - clearing status read releases interrupt pin
// - every event sets its flag regardless mask
// - flags other than bit 13 stay high until a clearing read or a reset event
// - clearing read returns flags then clears them
// - bit 0: active accumulator bit 14 change
// - bit 1: reactive accumulator bit 14 change
// - bit 2: apparent accumulator bit 15 rises
// - bits 3-5: voltage dip phases A,B,C
// - bits 6-8: crossing timeout phases A,B,C
// - bits 9-11: voltage zero cross A,B,C
// - bit 12: line-cycle accumulation finished
// - bit 14: selected voltage above peak threshold
// - bit 15: selected current above peak threshold
// - bit 16: new waveform sample ready
// - bit 17: active power sign flip, selected phases
// - bit 18: reactive power sign flip, selected phases
// - bit 19: A crossing followed by B
// - bit 13: reset event, one cycle high
// - phase select: one bit per phase A,B,C
`ifndef METER_IRQ_MAP_SVH
`define METER_IRQ_MAP_SVH

// ----------------------------------------
// register addresses
// ----------------------------------------
`define MIS_MASK_ADDR   7'h18
`define MIS_FLAGS_ADDR  7'h19
`define MIS_CLRRD_ADDR  7'h1A

// ----------------------------------------
// field positions
// ----------------------------------------
`define MIS_BIT_ACTHF   0
`define MIS_BIT_REACHF  1
`define MIS_BIT_APPHF   2
`define MIS_BIT_DIP     3
`define MIS_BIT_ZXTO    6
`define MIS_BIT_ZX      9
`define MIS_BIT_LCYC    12
`define MIS_BIT_RST     13
`define MIS_BIT_PKV     14
`define MIS_BIT_PKI     15
`define MIS_BIT_WAVE    16
`define MIS_BIT_REVA    17
`define MIS_BIT_REVR    18
`define MIS_BIT_SEQ     19

// ----------------------------------------
// reset values and masks
// ----------------------------------------
`define MIS_MASK_RST    20'h00000
`define MIS_FLAGS_RST   20'h02000
`define MIS_MASK_WRBITS 20'hFDFFF
`define MIS_STICKY      20'hFDFFF
`define MIS_SYNC_RST    3'h0

`endif

// ---- logic/meter_irq_pkg.sv ----
// types for the metering interrupt mask and status block
// assumes: the constants header sits beside it
`default_nettype none
package meter_irq_pkg;
  typedef logic [19:0] flags_t;    // one bit per source
  typedef logic [6:0]  reg_addr_t; // register address
  typedef logic [2:0]  phase_t;    // phases A,B,C in bits 0..2
  // phase order tracker
  typedef enum logic [1:0] {
    SEQ_IDLE    = 2'b01,
    SEQ_AFTER_A = 2'b10
  } seq_state_t;
endpackage : meter_irq_pkg
`default_nettype wire

// ---- verification/host_model.sv ----
// host model: register master and pulled-up interrupt line
// assumes: device takes strobes at the rising edge of clk
`timescale 1ns/100ps
`include "meter_irq_map.svh"
`default_nettype none
module host_model
  import meter_irq_pkg::*;
(
  // clock
  input  wire logic      clk,
  // register port toward the device
  output var reg_addr_t  regAddr,
  output var logic       regWrEn,
  output var logic       regRdEn,
  output var flags_t     regWrData,
  // interrupt pin parts from the device
  input  wire logic      irqOut,
  input  wire logic      irqOeN,
  output wire logic      irqPin
);
  // -----------
  // pin and idle bus
  // -----------
  // pull-up wins unless the device enables its driver
  assign irqPin = irqOeN ? 1'b1 : irqOut;

  // idle values at time zero
  initial begin
    regAddr   = 7'h00;
    regWrEn   = 1'b0;
    regRdEn   = 1'b0;
    regWrData = 20'h00000;
  end

  // -----------
  // accesses
  // -----------
  // one access after an idle gap; a slow host just waits longer
  task automatic access(input reg_addr_t a, input logic wr,
                        input flags_t d, input int gap);
    repeat (gap) @(posedge clk);
    @(posedge clk);
    regAddr   <= a;
    regWrEn   <= wr;
    regRdEn   <= !wr;
    regWrData <= wr ? d : ~regWrData;
    @(posedge clk);
    regWrEn   <= 1'b0;
    regRdEn   <= 1'b0;
    // stale address is not left on the bus
    regAddr   <= ~a;
  endtask : access

  // interrupt service: find the source first, then clear
  task automatic service(input int gap);
    access(`MIS_FLAGS_ADDR, 1'b0, 20'h00000, gap); // plain read
    access(`MIS_CLRRD_ADDR, 1'b0, 20'h00000, 0);
  endtask : service
endmodule : host_model
`default_nettype wire

// ---- verification/tb_top.sv ----
// bench for the metering interrupt mask and status block
// assumes: host model drives the register port, events come from here
`timescale 1ns/100ps
`include "meter_irq_map.svh"
`default_nettype none
module tb_top
  import meter_irq_pkg::*;
;
  // -----------
  // signals
  // -----------
  logic        ref_clk = 1'b0;        // 100 MHz
  logic        sys_rst = 1'b1;        // held at start
  reg_addr_t   regAddr;
  logic        regWrEn, regRdEn, regRdValid_r, irqOut_r, irqOeN_r;
  logic        irqPin;                // resolved open-drain level
  flags_t      regWrData, regRdData_r, mask;
  logic        supLow = 1'b0, softRst = 1'b0, lcDone = 1'b0;
  logic        voltage_peak_exceeded = 1'b0, current_peak_exceeded = 1'b0, wave = 1'b0;
  phase_t      actBit = '0, reaBit = '0, appBit = '0, dip = '0;
  phase_t      zxTo = '0, zx = '0, actSign = '0, reaSign = '0;
  phase_t      phaseSel = '0;
  flags_t      expQ[$];               // expected read data, oldest first
  logic [31:0] seed = 32'h0000EBEB;
  int          failures = 0, totalChecks = 0, cycles = 0, gap = 0;

  always #5 ref_clk = ~ref_clk;

  meter_interrupt_mask_status uut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .regAddr(regAddr),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regWrData(regWrData),
    .regRdData_r(regRdData_r), .regRdValid_r(regRdValid_r),
    .supplyLowPin(supLow), .softResetReq(softRst),
    .activeEnergyBit14(actBit), .reactiveEnergyBit14(reaBit),
    .apparentEnergyBit15(appBit), .voltageDip(dip),
    .crossingTimeout(zxTo), .zeroCross(zx),
    .lineCycleAccumDone(lcDone), .voltagePeakExceeded(voltage_peak_exceeded),
    .currentPeakExceeded(current_peak_exceeded), .waveformSampleReady(wave),
    .activePowerSign(actSign), .reactivePowerSign(reaSign),
    .phaseTermSelect(phaseSel), .irqOut_r(irqOut_r), .irqOeN_r(irqOeN_r)
  );

  host_model host (
    .clk(ref_clk), .regAddr(regAddr), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regWrData(regWrData), .irqOut(irqOut_r),
    .irqOeN(irqOeN_r), .irqPin(irqPin)
  );

  // -----------
  // helpers
  // -----------
  function automatic logic [31:0] nextRand();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : nextRand

  task automatic check(input string what, input flags_t e, input flags_t s);
    totalChecks++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, s);
    end
  endtask : check

  // note the expected word, then let the host read
  task automatic rd(input reg_addr_t a, input flags_t e);
    expQ.push_back(e);
    host.access(a, 1'b0, 20'h00000, gap);
  endtask : rd

  task automatic wr(input reg_addr_t a, input flags_t d);
    host.access(a, 1'b1, d, gap);
  endtask : wr

  // one event for flag b; e gets the flags it must leave set
  task automatic fire(input int b, output flags_t e);
    phase_t ph;
    ph = phase_t'(3'h1 << (nextRand() % 3));
    e = flags_t'(1) << b;
    @(posedge ref_clk);
    case (b)
      0: actBit <= actBit ^ ph;                    // bit 14 change
      1: reaBit <= reaBit ^ ph;                    // bit 14 change
      2: appBit <= ph;                             // rise of msb
      3, 4, 5: dip <= phase_t'(3'h1 << (b - 3));   // dip per phase
      6, 7, 8: zxTo <= phase_t'(3'h1 << (b - 6));  // timeout
      9: zx <= 3'h1;                               // A crossing
      10: begin                                    // B with C: no error
        zx <= 3'h6;
        e = e | 20'h00800;                         // B and C flags
      end
      11: zx <= 3'h4;                              // C crossing
      12: lcDone <= 1'b1;                          // cycles done
      14: voltage_peak_exceeded <= 1'b1;                             // voltage peak
      15: current_peak_exceeded <= 1'b1;                             // current peak
      16: wave <= 1'b1;                            // new sample
      17: begin                                    // one phase flips
        actSign <= actSign ^ ph;
        if ((phaseSel & ph) == '0) e = '0;         // not selected
      end
      18: begin
        reaSign <= reaSign ^ ph;
        if ((phaseSel & ph) == '0) e = '0;         // not selected
      end
      default: begin                               // A then B alone
        zx <= 3'h1;
        @(posedge ref_clk);
        zx <= 3'h2;
        e = e | 20'h00600;                         // A and B crossing flags
      end
    endcase
    @(posedge ref_clk);
    {dip, zxTo, zx, appBit} <= '0;                 // msb fall is quiet
    {lcDone, voltage_peak_exceeded, current_peak_exceeded, wave} <= '0;
  endtask : fire

  task automatic finish_test();
    $display("checks %0d failures %0d", totalChecks, failures);
    if (failures == 0 && totalChecks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finish_test

  // -----------
  // watchers
  // -----------
  // oldest note against each read answer, away from the edge
  always @(negedge ref_clk) begin
    if (regRdValid_r === 1'b1) begin
      check("read data", expQ.size() > 0 ? expQ.pop_front() : 20'hXXXXX,
            regRdData_r);
    end
  end

  // hang guard, far above the several hundred cycles needed
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      finish_test();
    end
  end

  // -----------
  // scenarios
  // -----------
  initial begin : main
    flags_t e;
    repeat (10) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(negedge ref_clk);
    check("pin after reset", 20'h00001, irqPin);   // released
    rd(`MIS_MASK_ADDR, `MIS_MASK_RST);             // mask reset value
    rd(`MIS_FLAGS_ADDR, 20'h00000);                // marker gone
    rd(7'h20, 20'h00000);                          // unmapped reads zero
    wr(`MIS_FLAGS_ADDR, 20'hFFFFF);
    rd(`MIS_FLAGS_ADDR, 20'h00000);                // read-only flags
    $display("test reset_state done");
    for (int b = 0; b < 20; b++) begin
      if (b == 13) continue;
      gap = nextRand() & 3;
      phaseSel <= phase_t'(nextRand());
      mask = flags_t'(nextRand());
      wr(`MIS_MASK_ADDR, mask);
      mask = mask & `MIS_MASK_WRBITS;
      rd(`MIS_MASK_ADDR, mask);                    // bit 13 not kept
      fire(b, e);
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
      check("pin on event", flags_t'(~|(e & mask)), irqPin);
      expQ.push_back(e);                           // flag set
      expQ.push_back(e);                           // plain read kept
      host.service(gap);                           // clearing read
      @(negedge ref_clk);
      check("pin after clear", 20'h00001, irqPin); // released
      rd(`MIS_FLAGS_ADDR, 20'h00000);              // flags cleared
    end
    $display("test event_sources done");
    wr(`MIS_MASK_ADDR, 20'hFFFFF);
    fire(3, e);
    @(posedge ref_clk);
    softRst <= 1'b1;
    expQ.push_back(`MIS_FLAGS_RST);                // one-cycle marker
    fork
      host.access(`MIS_FLAGS_ADDR, 1'b0, 20'h00000, 0);
      begin
        @(posedge ref_clk);
        softRst <= 1'b0;
      end
    join
    @(negedge ref_clk);
    check("pin after soft reset", 20'h00001, irqPin);
    rd(`MIS_FLAGS_ADDR, 20'h00000);                // marker one cycle
    rd(`MIS_MASK_ADDR, 20'h00000);                 // mask cleared
    $display("test soft_reset done");
    wr(`MIS_MASK_ADDR, 20'hFFFFF);
    fire(4, e);
    supLow <= 1'b1;
    repeat (8) @(posedge ref_clk);
    supLow <= 1'b0;
    @(negedge ref_clk);
    check("pin after supply drop", 20'h00001, irqPin);
    rd(`MIS_MASK_ADDR, 20'h00000);                 // mask cleared
    rd(`MIS_FLAGS_ADDR, 20'h00000);                // sticky flags gone
    $display("test supply_drop done");
    repeat (4) @(posedge ref_clk);
    check("reads left", 20'h00000, flags_t'(expQ.size()));
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
